/* File: rtl/mcd_pkg.sv */
package mcd_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] MCD_CTRL_B_ADDR = 8'h30;
    localparam logic [7:0] MCD_CTRL_B_RESET_GND = 8'h00;
    localparam logic [7:0] MCD_CTRL_B_RESET_VDD = 8'hD8;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int MCD_BIT_ENABLE = 7;
    localparam int MCD_BIT_MODE_HI = 6;
    localparam int MCD_BIT_MODE_LO = 5;
    localparam int MCD_BIT_OT_BEH = 4;
    localparam int MCD_BIT_WT_BEH = 3;
    localparam int MCD_BIT_COMBINE = 2;
    localparam int MCD_BIT_INSEL = 1;
    localparam int MCD_BIT_REFRESH = 0;

    localparam int MCD_AXIS_W = 12;
    localparam logic [11:0] MCD_REF_ZERO = 12'h000;
    localparam logic [7:0] MCD_CNT_ZERO = 8'h00;

    typedef enum logic [1:0] {
        MCD_UPD_ON_EVENT = 2'b00,
        MCD_UPD_FIXED = 2'b01,
        MCD_UPD_EVERY = 2'b10,
        MCD_UPD_ABSOLUTE = 2'b11
    } mcd_upd_mode_t;

    typedef struct packed {
        logic [11:0] x;
        logic [11:0] y;
        logic [11:0] z;
    } mcd_axes_t;

    typedef struct packed {
        logic [2:0] ot_axis;
        logic [2:0] wt_axis;
    } mcd_cond_t;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mcd_reg_wr_t;

endpackage

/* File: rtl/mcd_top.sv */
`timescale 1ns/1ps
// Functional notes
// [RQ1] enable bit 0 keeps detector off, clock and power gated; code gates only the clock, no power control.
// [RQ2] enable resets to 0 on ground strap, 1 on supply strap with motion option.
// [RQ3] setting enable initialises three 12-bit references per update mode.
// [RQ4] mode 00: first sample is reference; reload on outside event rising.
// [RQ5] mode 01: first sample held until re-enable or host refresh.
// [RQ6] mode 10: reference reloads with current sample after every evaluation.
// [RQ7] mode 11: references are zero, absolute comparison.
// [RQ8] outside behaviour 0: counter decrements on false samples.
// [RQ9] after outside flag, limit plus one false periods before next cycle.
// [RQ10] outside behaviour 1: counter cleared on false sample.
// [RQ11] inside behaviour 0: decrement on false; limit plus one false periods to rearm.
// [RQ12] inside behaviour 1: counter cleared on false sample.
// [RQ13] inside results combine by AND when bit 0, OR when bit 1.
// [RQ14] input select 1 uses magnitude on X only, Y and Z ignored.
// [RQ15] host must also enable magnitude calculation when selecting magnitude.
// [RQ16] refresh request reloads references; absolute mode keeps them zero.
// [RQ17] reload may wait up to one output data period after request.
// [RQ18] refresh bit self-clears once references reload.
// [RQ19] refresh bit writable in active or standby.
// [RQ20] each counter step lasts one output data period.
// [RQ21] counters reset on standby/active transitions and wake/sleep changes.
// [RQ22] counter increments on true sample; flag asserts at programmed limit.
module mcd_top (
    input wire logic clk,
    input wire logic rstn,
    input wire logic boot_strap_select,
    input wire logic motion_detect_option,
    input wire mcd_pkg::mcd_reg_wr_t reg_wr,
    output logic [7:0] change_detector_control_b,
    input wire logic sample_tick,
    input wire mcd_pkg::mcd_axes_t sample,
    input wire mcd_pkg::mcd_cond_t cond,
    input wire logic [7:0] outside_debounce_limit,
    input wire logic [7:0] inside_debounce_limit,
    input wire logic active,
    input wire logic wake_sleep_change,
    output logic detector_clock_enable,
    output mcd_pkg::mcd_axes_t reference,
    output logic [2:0] axis_in_use,
    output logic outside_event_active,
    output logic inside_event_active
);
    import mcd_pkg::*;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] strap_s1, strap_s2;
    logic [1:0] next_strap_s1, next_strap_s2;
    logic strap_done, next_strap_done;

    always_comb begin
        next_strap_s1 = {boot_strap_select, motion_detect_option};
        next_strap_s2 = strap_s1;
    end

    always_ff @(posedge clk) begin
        strap_s1 <= next_strap_s1;
        strap_s2 <= next_strap_s2;
    end

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    logic [7:0] ctrl, next_ctrl;
    logic ref_load;
    logic enable;
    mcd_upd_mode_t upd_mode;
    logic ctrl_wr;
    logic keep_refresh;

    assign enable = ctrl[MCD_BIT_ENABLE];
    assign upd_mode = mcd_upd_mode_t'(ctrl[MCD_BIT_MODE_HI:MCD_BIT_MODE_LO]);
    assign change_detector_control_b = ctrl;
    assign ctrl_wr = reg_wr.wr && (reg_wr.addr == MCD_CTRL_B_ADDR);
    // a host write of 1 in the clearing cycle is a fresh request and wins
    assign keep_refresh = ctrl_wr && reg_wr.wdata[MCD_BIT_REFRESH];

    always_comb begin
        next_ctrl = ctrl;
        next_strap_done = 1'b1;
        // strap is caught once, after the synchroniser has settled
        if (!strap_done) begin
            if (strap_s2 == 2'b11) begin // [RQ2]
                next_ctrl = MCD_CTRL_B_RESET_VDD;
            end else begin
                next_ctrl = MCD_CTRL_B_RESET_GND;
            end
        end else if (ctrl_wr) begin // [RQ19]
            next_ctrl = reg_wr.wdata;
        end
        if (strap_done && ctrl[MCD_BIT_REFRESH] && !keep_refresh) begin
            if (ref_load) begin
                next_ctrl[MCD_BIT_REFRESH] = 1'b0; // [RQ18]
            end else if (!ctrl[MCD_BIT_ENABLE]) begin
                // no sample will come while off, so drop the request
                next_ctrl[MCD_BIT_REFRESH] = 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // strap capture window
    // ----------------------------------------------------------------
    // host writes are refused until this window closes
    logic [1:0] strap_wait, next_strap_wait;

    always_comb begin
        next_strap_wait = strap_wait;
        if (strap_wait != 2'b11) begin
            next_strap_wait = strap_wait + 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl <= MCD_CTRL_B_RESET_GND;
            strap_done <= 1'b0;
            strap_wait <= 2'h0;
        end else begin
            ctrl <= next_ctrl;
            strap_done <= (strap_wait == 2'b11) ? next_strap_done : 1'b0;
            strap_wait <= next_strap_wait;
        end
    end

    // ----------------------------------------------------------------
    // axis selection output
    // ----------------------------------------------------------------
    logic [2:0] next_axis_in_use;

    // built from the next register value so the flop never lags the register
    always_comb begin
        next_axis_in_use = next_ctrl[MCD_BIT_INSEL] ? 3'h4 : 3'h7; // [RQ14]
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            axis_in_use <= 3'h7;
        end else begin
            axis_in_use <= next_axis_in_use;
        end
    end

    // ----------------------------------------------------------------
    // window condition combining
    // ----------------------------------------------------------------
    logic [2:0] axis_mask;
    logic ot_true, wt_true;
    logic [2:0] wt_used;

    always_comb begin
        axis_mask = ctrl[MCD_BIT_INSEL] ? 3'h4 : 3'h7; // [RQ14]
        // cond bit 2 is x; disabled axes arrive as zero from the comparators
        ot_true = |(cond.ot_axis & axis_mask);
        wt_used = cond.wt_axis & axis_mask;
        if (ctrl[MCD_BIT_COMBINE]) begin
            wt_true = |wt_used; // [RQ13]
        end else begin
            wt_true = (wt_used == axis_mask); // [RQ13]
        end
    end

    assign detector_clock_enable = enable; // [RQ1]

    // ----------------------------------------------------------------
    // debounce counters
    // ----------------------------------------------------------------
    logic [7:0] ot_cnt, wt_cnt, next_ot_cnt, next_wt_cnt;
    logic next_ot_flag, next_wt_flag;
    logic prev_active, next_prev_active;
    logic cnt_reset;

    // one step per sample tick, i.e. per output data period
    function automatic logic [8:0] mcd_step(
        input logic [7:0] cnt,
        input logic flag,
        input logic cond_true,
        input logic clear_mode,
        input logic [7:0] limit
    );
        logic [7:0] c;
        logic f;
        c = cnt;
        f = flag;
        if (cond_true) begin
            if (c < limit) begin
                c = c + 8'h01; // [RQ22]
            end
            if (c >= limit) begin
                f = 1'b1; // [RQ22]
            end
        end else if (clear_mode) begin
            c = MCD_CNT_ZERO; // [RQ10] [RQ12]
            f = 1'b0;
        end else begin
            // flag holds until counter has drained past zero: limit+1 false steps
            if (f) begin
                if (c == MCD_CNT_ZERO) begin
                    f = 1'b0; // [RQ9] [RQ11]
                end else begin
                    c = c - 8'h01; // [RQ8] [RQ11]
                end
            end else if (c != MCD_CNT_ZERO) begin
                c = c - 8'h01; // [RQ8] [RQ11]
            end
        end
        return {f, c};
    endfunction

    always_comb begin
        next_prev_active = active;
        cnt_reset = (active != prev_active) || wake_sleep_change || !enable; // [RQ21]
        next_ot_cnt = ot_cnt;
        next_wt_cnt = wt_cnt;
        next_ot_flag = outside_event_active;
        next_wt_flag = inside_event_active;
        if (cnt_reset) begin
            next_ot_cnt = MCD_CNT_ZERO;
            next_wt_cnt = MCD_CNT_ZERO;
            next_ot_flag = 1'b0;
            next_wt_flag = 1'b0;
        end else if (sample_tick) begin // [RQ20]
            {next_ot_flag, next_ot_cnt} = mcd_step(ot_cnt, outside_event_active, ot_true,
                ctrl[MCD_BIT_OT_BEH], outside_debounce_limit);
            {next_wt_flag, next_wt_cnt} = mcd_step(wt_cnt, inside_event_active, wt_true,
                ctrl[MCD_BIT_WT_BEH], inside_debounce_limit);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ot_cnt <= MCD_CNT_ZERO;
            wt_cnt <= MCD_CNT_ZERO;
            outside_event_active <= 1'b0;
            inside_event_active <= 1'b0;
            prev_active <= 1'b0;
        end else begin
            ot_cnt <= next_ot_cnt;
            wt_cnt <= next_wt_cnt;
            outside_event_active <= next_ot_flag;
            inside_event_active <= next_wt_flag;
            prev_active <= next_prev_active;
        end
    end

    // ----------------------------------------------------------------
    // reference values
    // ----------------------------------------------------------------
    mcd_axes_t next_reference;
    logic first_pending, next_first_pending;
    logic prev_enable, next_prev_enable;
    logic first_now;
    logic ot_rise;

    assign ot_rise = next_ot_flag && !outside_event_active;

    always_comb begin
        next_prev_enable = enable;
        // a tick in the very cycle enable rises must still catch the first sample
        first_now = first_pending || (enable && !prev_enable); // [RQ3]
        next_first_pending = first_now;
        next_reference = reference;
        ref_load = 1'b0;
        if (!enable) begin
            next_first_pending = 1'b0; // [RQ1]
        end else if (sample_tick) begin
            // loads land on the next sample, so a refresh waits at most one period
            case (upd_mode)
                MCD_UPD_ON_EVENT: ref_load = first_now || ot_rise
                    || ctrl[MCD_BIT_REFRESH]; // [RQ4] [RQ16] [RQ17]
                MCD_UPD_FIXED: ref_load = first_now
                    || ctrl[MCD_BIT_REFRESH]; // [RQ5] [RQ16] [RQ17]
                MCD_UPD_EVERY: ref_load = 1'b1; // [RQ6]
                MCD_UPD_ABSOLUTE: ref_load = ctrl[MCD_BIT_REFRESH]; // completes, no reload
                default: ref_load = 1'b0;
            endcase
            next_first_pending = 1'b0;
        end
        if (upd_mode == MCD_UPD_ABSOLUTE) begin
            next_reference = '{x: MCD_REF_ZERO, y: MCD_REF_ZERO, z: MCD_REF_ZERO}; // [RQ7] [RQ16]
        end else if (ref_load) begin
            next_reference = sample; // [RQ3]
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            reference <= '{x: MCD_REF_ZERO, y: MCD_REF_ZERO, z: MCD_REF_ZERO};
            first_pending <= 1'b0;
            prev_enable <= 1'b0;
        end else begin
            reference <= next_reference;
            first_pending <= next_first_pending;
            prev_enable <= next_prev_enable;
        end
    end

endmodule

/* File: verif/mcd_monitor.sv */
`timescale 1ns/1ps
module mcd_monitor (
    input wire logic clk,
    input wire logic rstn,
    input wire mcd_pkg::mcd_reg_wr_t reg_wr,
    input wire logic [7:0] change_detector_control_b,
    input wire logic sample_tick,
    input wire mcd_pkg::mcd_axes_t sample,
    input wire logic detector_clock_enable,
    input wire mcd_pkg::mcd_axes_t reference,
    input wire logic [2:0] axis_in_use,
    input wire logic outside_event_active,
    input wire logic inside_event_active
);
    import mcd_pkg::*;
    logic [7:0] c;
    assign c = change_detector_control_b;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // ------------------------------------------------
    // sequences
    // ------------------------------------------------
    sequence s_off;
        !c[7] ##1 !c[7];
    endsequence
    // a tick is needed first, though the forced zero lands the clock after mode 11 without waiting for a step
    sequence s_abs;
        c[6:5] == 2'b11 && c[7] && sample_tick ##1 c[6:5] == 2'b11;
    endsequence
    sequence s_pend_tick;
        c[0] && c[7] && c[6:5] != 2'b11 && sample_tick && !reg_wr.wr;
    endsequence
    a_clock_off: assert property (s_off |-> !detector_clock_enable)
        else $error("clock enable high while off");
    a_flags_off: assert property (s_off |-> !outside_event_active && !inside_event_active)
        else $error("flag high while off");
    a_abs_zero: assert property (s_abs |-> reference == '0)
        else $error("reference not zero");
    a_axis_select: assert property (axis_in_use == (c[1] ? 3'b100 : 3'b111))
        else $error("axis select wrong");
    a_slope_reload: assert property (sample_tick && c[7] && c[6:5] == 2'b10
        |=> reference == $past(sample))
        else $error("reference not last sample");
    a_write_lands: assert property (reg_wr.wr && reg_wr.addr == MCD_CTRL_B_ADDR
        |=> c == $past(reg_wr.wdata))
        else $error("write lost");
    a_refresh_done: assert property (c[0] |-> ##[1:8] !c[0])
        else $error("refresh bit stuck");
    a_refresh_load: assert property (s_pend_tick |=> reference == $past(sample) && !c[0])
        else $error("refresh did not reload");
endmodule
bind mcd_top mcd_monitor mcd_monitor_inst (.clk(clk), .rstn(rstn), .reg_wr(reg_wr),
    .change_detector_control_b(change_detector_control_b), .sample_tick(sample_tick),
    .sample(sample), .detector_clock_enable(detector_clock_enable), .reference(reference),
    .axis_in_use(axis_in_use), .outside_event_active(outside_event_active),
    .inside_event_active(inside_event_active));

/* File: verif/tb_mcd_top.sv */
`timescale 1ns/1ps
module tb_mcd_top;
    import mcd_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic strap = 1'b0;
    logic sample_tick = 1'b0;
    logic wake = 1'b0;
    logic act = 1'b1;
    mcd_reg_wr_t reg_wr = '0;
    mcd_axes_t sample = '0;
    mcd_cond_t cond = '0;
    logic [7:0] ctrl;
    logic clk_en;
    mcd_axes_t reference;
    logic [2:0] axis_in_use;
    logic ot_flag;
    logic wt_flag;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    mcd_top mcd_top_inst (.clk(clk), .rstn(rstn), .boot_strap_select(strap),
        .motion_detect_option(strap), .reg_wr(reg_wr), .change_detector_control_b(ctrl),
        .sample_tick(sample_tick), .sample(sample), .cond(cond),
        .outside_debounce_limit(8'h02), .inside_debounce_limit(8'h01), .active(act),
        .wake_sleep_change(wake), .detector_clock_enable(clk_en), .reference(reference),
        .axis_in_use(axis_in_use), .outside_event_active(ot_flag),
        .inside_event_active(wt_flag));
    initial begin
        forever #2 clk = ~clk;
    end
    // ------------------------------------------------
    // access tasks
    // ------------------------------------------------
    function automatic mcd_axes_t ax(input logic [11:0] v);
        return '{v, v + 12'h001, v + 12'h002};
    endfunction
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr = '{1'b1, a, d};
        cyc(1);
        reg_wr.wr = 1'b0;
        cyc(2);
    endtask
    task automatic tick(input logic [11:0] v, input logic [5:0] c);
        sample = ax(v);
        cond = c;
        sample_tick = 1'b1;
        cyc(1);
        sample_tick = 1'b0;
        cyc(2);
    endtask
    // strap load follows release by a few cycles, so wait past it
    task automatic do_reset(input logic s);
        rstn = 1'b0;
        strap = s;
        cyc(6);
        rstn = 1'b1;
        cyc(8);
    endtask
    task automatic close_out();
        if (num_errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            close_out();
        end
    end
    initial begin
        do_reset(1'b0);
        chk(ctrl, 8'h00);
        wr(8'h31, 8'hFF);
        chk({ctrl, clk_en}, 9'h000);
        wr(8'h30, 8'hA0);
        tick(12'h123, 6'h00);
        chk({clk_en, reference}, {1'b1, ax(12'h123)});
        tick(12'h456, 6'h00);
        chk(reference, ax(12'h123));
        wr(8'h30, 8'hA1);
        tick(12'h789, 6'h00);
        chk({ctrl, reference}, {8'hA0, ax(12'h789)});
        wr(8'h30, 8'hC0);
        tick(12'h0AB, 6'h00);
        tick(12'hFFD, 6'h00);
        chk(reference, ax(12'hFFD));
        wr(8'h30, 8'hE1);
        tick(12'h555, 6'h00);
        chk({ctrl, reference}, {8'hE0, 36'h0});
        wr(8'h30, 8'h00);
        chk({clk_en, ot_flag, wt_flag}, 3'b000);
        wr(8'h30, 8'h80);
        tick(12'h100, 6'h00);
        tick(12'h200, 6'h20);
        chk({ot_flag, reference}, {1'b0, ax(12'h100)});
        tick(12'h300, 6'h20);
        chk({ot_flag, reference}, {1'b1, ax(12'h300)});
        tick(12'h400, 6'h00);
        tick(12'h400, 6'h00);
        chk(ot_flag, 1'b1);
        tick(12'h400, 6'h00);
        chk(ot_flag, 1'b0);
        wr(8'h30, 8'h90);
        tick(12'h400, 6'h20);
        tick(12'h400, 6'h20);
        chk(ot_flag, 1'b1);
        tick(12'h400, 6'h00);
        chk(ot_flag, 1'b0);
        tick(12'h400, 6'h07);
        chk(wt_flag, 1'b1);
        tick(12'h400, 6'h00);
        chk(wt_flag, 1'b1);
        tick(12'h400, 6'h00);
        chk(wt_flag, 1'b0);
        wr(8'h30, 8'h88);
        tick(12'h400, 6'h06);
        chk(wt_flag, 1'b0);
        tick(12'h400, 6'h07);
        chk(wt_flag, 1'b1);
        tick(12'h400, 6'h06);
        chk(wt_flag, 1'b0);
        wr(8'h30, 8'h8C);
        tick(12'h400, 6'h02);
        chk(wt_flag, 1'b1);
        wake = 1'b1;
        cyc(1);
        wake = 1'b0;
        cyc(2);
        chk(wt_flag, 1'b0);
        tick(12'h400, 6'h02);
        chk(wt_flag, 1'b1);
        act = 1'b0;
        cyc(1);
        chk(wt_flag, 1'b0);
        act = 1'b1;
        cyc(2);
        wr(8'h30, 8'h82); // magnitude calc enable assumed set upstream
        chk(axis_in_use, 3'b100);
        tick(12'h400, 6'h1B);
        chk({ot_flag, wt_flag}, 2'b00);
        tick(12'h400, 6'h24);
        chk({ot_flag, wt_flag}, 2'b01);
        wr(8'h30, 8'h01);
        chk(ctrl, 8'h00);
        do_reset(1'b1);
        chk(ctrl, 8'hD8);
        close_out();
    end
endmodule
